// [tcc_ccp.sv]
// Purpose: 16-bit timer with two compares, input capture and phase-correct pwm
// Assumes: ahb-lite single word transfers; data in byte lane 0
// Notes: every transfer takes one wait state; haddr above bit 9 is not decoded
// How it works
// - two 16-bit compare values checked every count
// - only counting, not writes, produces a match
// - compare flag set the cycle after match
// - high byte to holding, low loads both
// - capture edge copies count and sets flag
// - capture register is read-only, 16 bits
// - low capture read moves high into holding
// - pwm counts up to top and back
// - top is 255, 511 or 1023
// - pwm compares only ten low bits
// - pwm action codes clear/set by direction
// - pwm compare writes latch at top
// - compare reads return latest written value
// - zero or top gives fixed low/high level
// - top with undivided clock gives no pulse
// - top with prescaler goes active at top
// - pwm overflow flag set leaving zero
// - flags request interrupts when both enabled
// - two-bit field selects pwm resolution
// - edge select picks falling or rising capture
// - clock select stops, divides or uses pin
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "tcc_ccp_defines.svh"
module tcc_ccp (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        capture_input_pin,
    input  wire logic        ext_clock_pin,
    input  wire logic        global_irq_enable,
    output logic             compare_out_a,
    output logic             compare_out_a_drive,
    output logic             compare_out_b,
    output logic             compare_out_b_drive,
    output logic      [3:0]  irq_req
);
    tcc_pkg::tcc_bus_t bus_state_reg;
    logic [7:0]  acc_idx_reg;
    logic        acc_wr_reg;
    logic [31:0] hrdata_reg;
    logic        hreadyout_reg;
    logic [7:0]  ctrl_a_reg;
    logic [7:0]  ctrl_b_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  irq_en_reg;
    logic [7:0]  temp_reg;
    logic [15:0] timer_count_reg;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_a_buf_reg;
    logic [15:0] cmp_b_reg;
    logic [15:0] cmp_b_buf_reg;
    logic [15:0] capture_value_reg;
    logic [9:0]  pre_reg;
    logic        counted_reg;
    logic        dir_up_reg;
    logic        out_a_reg;
    logic        out_a_drv_reg;
    logic        out_b_reg;
    logic        out_b_drv_reg;
    logic [3:0]  irq_reg;

    function automatic logic cmp_hit(input logic [15:0] cnt, input logic [15:0] val, input logic pwm);
        if (pwm) begin
            return cnt[`TCC_PWM_MSB:0] == val[`TCC_PWM_MSB:0];
        end
        return cnt == val;
    endfunction : cmp_hit

    // next pin level on a match; top in pwm is handled as the down-count match, except with the undivided clock, where the level is kept
    function automatic logic pin_action(input logic [1:0] code, input logic cur, input logic pwm,
                                        input logic up_ev, input logic top_ev, input logic undiv);
        if (!pwm) begin
            return (code == 2'b00) ? cur : (code == 2'b01) ? ~cur : code[0];
        end
        if (!code[1]) begin
            return cur;
        end
        if (top_ev) begin
            return undiv ? cur : ~code[0];
        end
        return up_ev ? code[0] : ~code[0];
    endfunction : pin_action

    function automatic logic [15:0] top_of(input tcc_pkg::tcc_pwm_t sel);
        case (sel)
            tcc_pkg::PWM_8BIT: return `TCC_TOP8;
            tcc_pkg::PWM_9BIT: return `TCC_TOP9;
            default:           return `TCC_TOP10;
        endcase
    endfunction : top_of

    // bus decode
    wire logic       accept   = hsel & htrans[1] & hready & (bus_state_reg == tcc_pkg::BUS_IDLE);
    wire logic       acc      = (bus_state_reg == tcc_pkg::BUS_DATA);
    wire logic       wr       = acc & acc_wr_reg;
    wire logic       rd       = acc & ~acc_wr_reg;
    wire logic [7:0] wdat     = hwdata[7:0];
    wire logic       s_capt_l = (acc_idx_reg == `TCC_IDX_CAPT_LO);
    wire logic       s_capt_h = (acc_idx_reg == `TCC_IDX_CAPT_HI);
    wire logic       s_cmpb_l = (acc_idx_reg == `TCC_IDX_CMPB_LO);
    wire logic       s_cmpb_h = (acc_idx_reg == `TCC_IDX_CMPB_HI);
    wire logic       s_cmpa_l = (acc_idx_reg == `TCC_IDX_CMPA_LO);
    wire logic       s_cmpa_h = (acc_idx_reg == `TCC_IDX_CMPA_HI);
    wire logic       s_cnt_l  = (acc_idx_reg == `TCC_IDX_CNT_LO);
    wire logic       s_cnt_h  = (acc_idx_reg == `TCC_IDX_CNT_HI);
    wire logic       s_ctb    = (acc_idx_reg == `TCC_IDX_CTRL_B);
    wire logic       s_cta    = (acc_idx_reg == `TCC_IDX_CTRL_A);
    wire logic       s_flags  = (acc_idx_reg == `TCC_IDX_FLAGS);
    wire logic       s_irq_en = (acc_idx_reg == `TCC_IDX_IRQ_EN);
    wire logic       wr_cnt_l = wr & s_cnt_l;
    wire logic       wr_cmpa  = wr & s_cmpa_l;
    wire logic       wr_cmpb  = wr & s_cmpb_l;
    wire logic [7:0] capt_hi  = capture_value_reg[15:8];

    // high bytes of counter and capture come back through the holding byte
    logic [7:0] rd_val;
    always_comb begin
        if (s_capt_l) begin
            rd_val = capture_value_reg[7:0];
        end else if (s_capt_h || s_cnt_h) begin
            rd_val = temp_reg;
        end else if (s_cmpb_l) begin
            rd_val = cmp_b_buf_reg[7:0];
        end else if (s_cmpb_h) begin
            rd_val = cmp_b_buf_reg[15:8];
        end else if (s_cmpa_l) begin
            rd_val = cmp_a_buf_reg[7:0];
        end else if (s_cmpa_h) begin
            rd_val = cmp_a_buf_reg[15:8];
        end else if (s_cnt_l) begin
            rd_val = timer_count_reg[7:0];
        end else if (s_cta) begin
            rd_val = ctrl_a_reg;
        end else if (s_ctb) begin
            rd_val = ctrl_b_reg;
        end else if (s_flags) begin
            rd_val = flags_reg;
        end else if (s_irq_en) begin
            rd_val = irq_en_reg;
        end else begin
            rd_val = `TCC_RST_BYTE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= tcc_pkg::BUS_IDLE;
            acc_idx_reg   <= `TCC_RST_BYTE;
            acc_wr_reg    <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h0000_0000;
        end else begin
            case (bus_state_reg)
                tcc_pkg::BUS_IDLE: begin
                    if (accept) begin
                        acc_idx_reg   <= haddr[9:2];
                        acc_wr_reg    <= hwrite;
                        hreadyout_reg <= 1'b0;
                        bus_state_reg <= tcc_pkg::BUS_DATA;
                    end
                end
                default: begin
                    hreadyout_reg <= 1'b1;
                    hrdata_reg    <= {24'h00_0000, rd ? rd_val : `TCC_RST_BYTE};
                    bus_state_reg <= tcc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // control, enables and holding byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_a_reg <= `TCC_RST_BYTE;
            ctrl_b_reg <= `TCC_RST_BYTE;
            irq_en_reg <= `TCC_RST_BYTE;
            temp_reg   <= `TCC_RST_BYTE;
        end else begin
            if (wr && s_cta) begin
                ctrl_a_reg <= wdat & `TCC_CTA_MASK;
            end
            if (wr && s_ctb) begin
                ctrl_b_reg <= wdat & `TCC_CTB_MASK;
            end
            if (wr && s_irq_en) begin
                irq_en_reg <= wdat & `TCC_FLG_MASK;
            end
            if (wr && (s_cmpa_h || s_cmpb_h || s_cnt_h)) begin
                temp_reg <= wdat;
            end else if (rd && s_capt_l) begin
                temp_reg <= capt_hi;
            end else if (rd && s_cnt_l) begin
                temp_reg <= timer_count_reg[15:8];
            end
        end
    end

    // clock selection and prescaler
    wire tcc_pkg::tcc_pwm_t pwm_sel = tcc_pkg::tcc_pwm_t'(ctrl_a_reg[`TCC_CTA_PWM_HI:`TCC_CTA_PWM_LO]);
    wire tcc_pkg::tcc_clk_t cs_sel  = tcc_pkg::tcc_clk_t'(ctrl_b_reg[`TCC_CTB_CS_HI:0]);
    wire logic        pwm_on = (pwm_sel != tcc_pkg::PWM_OFF);
    wire logic [15:0] top    = top_of(pwm_sel);
    wire logic        undiv  = (cs_sel == tcc_pkg::CS_CK);
    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;

    tcc_pin_edge u_ext_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (ext_clock_pin),
        .rise    (ext_rise),
        .fall    (ext_fall)
    );

    tcc_pin_edge u_cap_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (capture_input_pin),
        .rise    (cap_rise),
        .fall    (cap_fall)
    );

    logic tick;
    always_comb begin
        case (cs_sel)
            tcc_pkg::CS_STOP:     tick = 1'b0;
            tcc_pkg::CS_CK:       tick = 1'b1;
            tcc_pkg::CS_DIV8:     tick = (pre_reg & `TCC_PRE_DIV8) == `TCC_PRE_DIV8;
            tcc_pkg::CS_DIV64:    tick = (pre_reg & `TCC_PRE_DIV64) == `TCC_PRE_DIV64;
            tcc_pkg::CS_DIV256:   tick = (pre_reg & `TCC_PRE_DIV256) == `TCC_PRE_DIV256;
            tcc_pkg::CS_DIV1024:  tick = (pre_reg & `TCC_PRE_DIV1024) == `TCC_PRE_DIV1024;
            tcc_pkg::CS_EXT_FALL: tick = ext_fall;
            default:              tick = ext_rise;
        endcase
    end

    // counter: up in normal mode, up/down between zero and top in pwm
    wire logic        count_ev = tick & ~wr_cnt_l;
    wire logic        at_top   = (timer_count_reg >= top);
    wire logic        at_bot   = (timer_count_reg == `TCC_RST_WORD);
    wire logic        top_eq   = (timer_count_reg == top);
    wire logic [15:0] cnt_inc  = timer_count_reg + 16'h0001;
    wire logic [15:0] cnt_dec  = timer_count_reg - 16'h0001;
    wire logic [15:0] cnt_step = !pwm_on ? cnt_inc :
                                 dir_up_reg ? (at_top ? cnt_dec : cnt_inc) : (at_bot ? cnt_inc : cnt_dec);
    wire logic        latch_top = pwm_on & count_ev & (cnt_step == top);
    wire logic        ovf_ev   = count_ev & (pwm_on ? at_bot : (timer_count_reg == 16'hffff));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg         <= `TCC_RST_PRE;
            timer_count_reg <= `TCC_RST_WORD;
            counted_reg     <= 1'b0;
            dir_up_reg      <= 1'b1;
        end else begin
            pre_reg     <= pre_reg + 10'h001;
            counted_reg <= count_ev;
            if (wr_cnt_l) begin
                timer_count_reg <= {temp_reg, wdat};
            end else if (tick) begin
                timer_count_reg <= cnt_step;
            end
            if (!pwm_on) begin
                dir_up_reg <= 1'b1;
            end else if (count_ev && at_top) begin
                dir_up_reg <= 1'b0;
            end else if (count_ev && at_bot) begin
                dir_up_reg <= 1'b1;
            end
        end
    end

    // compare values: buffered in pwm, direct otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_a_reg     <= `TCC_RST_WORD;
            cmp_a_buf_reg <= `TCC_RST_WORD;
            cmp_b_reg     <= `TCC_RST_WORD;
            cmp_b_buf_reg <= `TCC_RST_WORD;
        end else begin
            if (wr_cmpa) begin
                cmp_a_buf_reg <= {temp_reg, wdat};
            end
            if (wr_cmpb) begin
                cmp_b_buf_reg <= {temp_reg, wdat};
            end
            if (wr_cmpa && !pwm_on) begin
                cmp_a_reg <= {temp_reg, wdat};
            end else if (!pwm_on || latch_top) begin
                cmp_a_reg <= cmp_a_buf_reg;
            end
            if (wr_cmpb && !pwm_on) begin
                cmp_b_reg <= {temp_reg, wdat};
            end else if (!pwm_on || latch_top) begin
                cmp_b_reg <= cmp_b_buf_reg;
            end
        end
    end

    // match only in the cycle after the counter itself moved
    wire logic match_a = counted_reg & cmp_hit(timer_count_reg, cmp_a_reg, pwm_on);
    wire logic match_b = counted_reg & cmp_hit(timer_count_reg, cmp_b_reg, pwm_on);
    wire logic up_ev   = at_bot | (~top_eq & dir_up_reg);
    wire logic [1:0] code_a = ctrl_a_reg[`TCC_CTA_OUTA_HI:`TCC_CTA_OUTA_LO];
    wire logic [1:0] code_b = ctrl_a_reg[`TCC_CTA_OUTB_HI:`TCC_CTA_OUTB_LO];
    wire logic cap_edge = ctrl_b_reg[`TCC_CTB_EDGE] ? cap_rise : cap_fall;
    wire logic [7:0] flags_set = {4'h0, cap_edge, match_b, match_a, ovf_ev};
    wire logic [7:0] flags_clr = (wr && s_flags) ? wdat : `TCC_RST_BYTE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_a_reg         <= 1'b0;
            out_b_reg         <= 1'b0;
            out_a_drv_reg     <= 1'b0;
            out_b_drv_reg     <= 1'b0;
            capture_value_reg <= `TCC_RST_WORD;
            flags_reg         <= `TCC_RST_BYTE;
            irq_reg           <= 4'h0;
        end else begin
            if (match_a) begin
                out_a_reg <= pin_action(code_a, out_a_reg, pwm_on, up_ev, top_eq, undiv);
            end
            if (match_b) begin
                out_b_reg <= pin_action(code_b, out_b_reg, pwm_on, up_ev, top_eq, undiv);
            end
            out_a_drv_reg <= pwm_on ? code_a[1] : (code_a != 2'b00);
            out_b_drv_reg <= pwm_on ? code_b[1] : (code_b != 2'b00);
            if (cap_edge) begin
                capture_value_reg <= timer_count_reg;
            end
            // a set in the cycle of a clear wins
            flags_reg <= (flags_reg & ~flags_clr) | flags_set;
            irq_reg   <= flags_reg[3:0] & irq_en_reg[3:0] & {4{global_irq_enable}};
        end
    end

    assign hrdata              = hrdata_reg;
    assign hreadyout           = hreadyout_reg;
    assign hresp               = 1'b0;
    assign compare_out_a       = out_a_reg;
    assign compare_out_a_drive = out_a_drv_reg;
    assign compare_out_b       = out_b_reg;
    assign compare_out_b_drive = out_b_drv_reg;
    assign irq_req             = irq_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    cmp_flag_late_a: assert property (match_a |=> flags_reg[`TCC_FLG_CMPA])
        else $error("compare flag not set after match");
    cmp_no_write_a: assert property ($rose(flags_reg[`TCC_FLG_CMPA]) |-> $past(counted_reg))
        else $error("compare flag without counting");
    cmp_pair_load_a: assert property (wr_cmpa |=> cmp_a_buf_reg == {$past(temp_reg), $past(wdat)})
        else $error("compare low write did not load both bytes");
    cap_load_a: assert property (cap_edge |=> capture_value_reg == $past(timer_count_reg)
                                 && flags_reg[`TCC_FLG_CAPT])
        else $error("capture did not take counter and flag");
    cap_readonly_a: assert property (wr && (s_capt_l || s_capt_h) && !cap_edge |=> $stable(capture_value_reg))
        else $error("capture register changed by write");
    cap_hold_byte_a: assert property (rd && s_capt_l |=> temp_reg == $past(capt_hi))
        else $error("capture high byte not held");
    pwm_turn_a: assert property (pwm_on && count_ev && top_eq ##1 pwm_on && !wr_cnt_l && tick
                                 |=> (timer_count_reg + 16'h0002) == $past(top, 2))
        else $error("pwm counter did not reverse at top");
    pwm_buffered_a: assert property (pwm_on && !latch_top |=> $stable(cmp_a_reg))
        else $error("active compare changed outside top");
    pwm_clear_up_a: assert property (match_a && pwm_on && code_a == 2'b10 && up_ev && !top_eq
                                     |=> !out_a_reg)
        else $error("up-count match did not clear output");
    pwm_no_pulse_a: assert property (match_a && pwm_on && top_eq && undiv |=> $stable(out_a_reg))
        else $error("pulse at top with undivided clock");
    pwm_ovf_a: assert property (pwm_on && count_ev && at_bot |=> flags_reg[`TCC_FLG_OVF])
        else $error("overflow flag not set leaving zero");
    irq_gate_a: assert property (flags_reg[0] && irq_en_reg[0] && global_irq_enable |=> irq_reg[0])
        else $error("overflow request missing");

    cap_seen_c: cover property (cap_edge);
    pwm_latch_c: cover property (latch_top);
    pwm_match_c: cover property (match_a && pwm_on);
    ovf_seen_c: cover property (ovf_ev);
    pwm_top_c: cover property (match_a && pwm_on && top_eq && undiv);
endmodule : tcc_ccp

// [tcc_ccp_defines.svh]
// Purpose: offsets, field positions, reset values and counts of the timer compare/capture block
// Assumes: register index times four is the byte address
// Notes: definitions only
`ifndef TCC_CCP_DEFINES_SVH
`define TCC_CCP_DEFINES_SVH

// register indices
`define TCC_IDX_CAPT_LO 8'h24
`define TCC_IDX_CAPT_HI 8'h25
`define TCC_IDX_CMPB_LO 8'h28
`define TCC_IDX_CMPB_HI 8'h29
`define TCC_IDX_CMPA_LO 8'h2a
`define TCC_IDX_CMPA_HI 8'h2b
`define TCC_IDX_CNT_LO  8'h2c
`define TCC_IDX_CNT_HI  8'h2d
`define TCC_IDX_CTRL_B  8'h2e
`define TCC_IDX_CTRL_A  8'h2f
`define TCC_IDX_FLAGS   8'h38
`define TCC_IDX_IRQ_EN  8'h39

// timer_control_a fields
`define TCC_CTA_OUTA_HI 7
`define TCC_CTA_OUTA_LO 6
`define TCC_CTA_OUTB_HI 5
`define TCC_CTA_OUTB_LO 4
`define TCC_CTA_PWM_HI  1
`define TCC_CTA_PWM_LO  0
`define TCC_CTA_MASK    8'hf3
// timer_control_b fields
`define TCC_CTB_EDGE    6
`define TCC_CTB_CS_HI   2
`define TCC_CTB_MASK    8'h47
// flag and enable bits
`define TCC_FLG_OVF     0
`define TCC_FLG_CMPA    1
`define TCC_FLG_CMPB    2
`define TCC_FLG_CAPT    3
`define TCC_FLG_MASK    8'h0f

// reset values
`define TCC_RST_BYTE    8'h00
`define TCC_RST_WORD    16'h0000
`define TCC_RST_PRE     10'h000

// pwm top values
`define TCC_TOP8        16'h00ff
`define TCC_TOP9        16'h01ff
`define TCC_TOP10       16'h03ff
`define TCC_PWM_MSB     9

// prescaler masks: a tick when all masked bits are one
`define TCC_PRE_DIV8    10'h007
`define TCC_PRE_DIV64   10'h03f
`define TCC_PRE_DIV256  10'h0ff
`define TCC_PRE_DIV1024 10'h3ff

`endif

// [tcc_pkg.sv]
// Purpose: types of the timer compare/capture block
// Assumes: nothing
// Notes: codes follow declaration order
package tcc_pkg;
    typedef enum logic {BUS_IDLE, BUS_DATA} tcc_bus_t;
    typedef enum logic [1:0] {PWM_OFF, PWM_8BIT, PWM_9BIT, PWM_10BIT} tcc_pwm_t;
    typedef enum logic [2:0] {CS_STOP, CS_CK, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024,
                              CS_EXT_FALL, CS_EXT_RISE} tcc_clk_t;
endpackage : tcc_pkg

// [tcc_pin_edge.sv]
// Purpose: bring an outside pin into the clock domain and find its edges
// Assumes: pin is asynchronous to hclk
// Notes: a change counts once the second and third stage agree
`timescale 1ns/10ps
module tcc_pin_edge (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output wire logic rise,
    output wire logic fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    wire  logic agree = (s2_reg == s3_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign rise = agree & s3_reg & ~level_reg;
    assign fall = agree & ~s3_reg & level_reg;
endmodule : tcc_pin_edge

// [tcc_far_end.sv]
// Purpose: far side of the timer block: capture signal source and count pin
// Assumes: the bench commands the capture level
// Notes: pins move just after the clock edge
`timescale 1ns/10ps
module tcc_far_end (
    input  wire logic hclk,
    input  wire logic cap_level,
    output logic      capture_input_pin,
    output logic      ext_clock_pin
);
    logic [1:0] div_reg;
    initial begin
        capture_input_pin = 1'b0;
        ext_clock_pin = 1'b0;
        div_reg = 2'h0;
    end
    // count pin never selected by the bench; it only stays defined
    always @(posedge hclk) begin
        capture_input_pin <= #1 cap_level;
        div_reg <= div_reg + 2'h1;
        ext_clock_pin <= #1 div_reg[1];
    end
endmodule : tcc_far_end

// [timer16_compare_capture_pwm_tb.sv]
// Purpose: self-checking bench of the timer compare/capture block
// Assumes: one slave, hready tied to hreadyout
// Notes: bench never interrupts a 16-bit access
`timescale 1ns/10ps
`include "tcc_ccp_defines.svh"
module timer16_compare_capture_pwm_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        cap_level = 1'b0;
    logic        glob_en = 1'b1;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, cap_pin, ext_pin, out_a, out_a_drv, out_b, out_b_drv;
    logic [3:0]  irq_req;
    int          num_errors = 0;
    int          cmp_count = 0;
    always #10 hclk = ~hclk;
    tcc_ccp uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(cap_pin), .ext_clock_pin(ext_pin),
        .global_irq_enable(glob_en), .compare_out_a(out_a), .compare_out_a_drive(out_a_drv),
        .compare_out_b(out_b), .compare_out_b_drive(out_b_drv), .irq_req(irq_req));
    tcc_far_end far (.hclk(hclk), .cap_level(cap_level), .capture_input_pin(cap_pin),
        .ext_clock_pin(ext_pin));
    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_ready
    // address phase held until hready, then data phase held until hready again
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata[7:0];
        hsel <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        xfer(1'b1, idx, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        xfer(1'b0, idx, 8'h00, x);
        check({24'h0, x}, {24'h0, exp});
    endtask : rd
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo + 8'h01, v[15:8]);
        wr(lo, v[7:0]);
    endtask : wr16
    task automatic pin(input logic v);
        @(posedge hclk);
        cap_level <= v;
        repeat (8) @(posedge hclk);
    endtask : pin
    task automatic rise(output int c);
        logic prev;
        c = 0;
        do begin
            prev = out_a;
            @(posedge hclk);
            c++;
        end while (!(prev === 1'b0 && out_a === 1'b1) && c < 5000);
        if (c >= 5000) begin
            num_errors++;
            report_and_stop();
        end
    endtask : rise
    task automatic t_reset();
        // 0x26 and 0x27 are unmapped and read zero
        for (int i = 0; i < 8; i++) begin
            rd(8'h24 + 8'(i), 8'h00);
        end
    endtask : t_reset
    task automatic t_compare();
        wr16(`TCC_IDX_CMPA_LO, 16'h1234);
        wr16(`TCC_IDX_CMPB_LO, 16'habcd);
        wr(`TCC_IDX_CMPA_HI, 8'h56);
        rd(`TCC_IDX_CMPA_HI, 8'h12);
        rd(`TCC_IDX_CMPA_LO, 8'h34);
        rd(`TCC_IDX_CMPB_HI, 8'hab);
        rd(`TCC_IDX_CMPB_LO, 8'hcd);
    endtask : t_compare
    task automatic t_match();
        wr16(`TCC_IDX_CNT_LO, 16'h0050);
        wr16(`TCC_IDX_CMPA_LO, 16'h0050);
        wr(`TCC_IDX_FLAGS, 8'h0f);
        wr(`TCC_IDX_IRQ_EN, 8'h02);
        rd(`TCC_IDX_FLAGS, 8'h00);
        wr16(`TCC_IDX_CMPA_LO, 16'h0070);
        wr(`TCC_IDX_CTRL_B, 8'h01);
        repeat (60) @(posedge hclk);
        rd(`TCC_IDX_FLAGS, 8'h02);
        check({28'h0, irq_req}, 32'h0000_0002);
        // global enable low must mask the request one cycle later
        glob_en <= 1'b0;
        repeat (2) @(posedge hclk);
        check({28'h0, irq_req}, 32'h0000_0000);
        glob_en <= 1'b1;
    endtask : t_match
    task automatic t_capture();
        wr(`TCC_IDX_CTRL_B, 8'h40);
        wr16(`TCC_IDX_CNT_LO, 16'h1234);
        wr(`TCC_IDX_FLAGS, 8'h0f);
        pin(1'b1);
        rd(`TCC_IDX_FLAGS, 8'h08);
        wr(`TCC_IDX_CAPT_LO, 8'hff);
        wr(`TCC_IDX_CAPT_HI, 8'hff);
        wr16(`TCC_IDX_CNT_LO, 16'h0777);
        pin(1'b0);
        rd(`TCC_IDX_CAPT_LO, 8'h34);
        rd(`TCC_IDX_CAPT_HI, 8'h12);
        wr(`TCC_IDX_CTRL_B, 8'h00);
        pin(1'b1);
        pin(1'b0);
        rd(`TCC_IDX_CAPT_LO, 8'h77);
        rd(`TCC_IDX_CAPT_HI, 8'h07);
    endtask : t_capture
    task automatic t_pwm();
        int c;
        for (int r = 1; r < 4; r++) begin
            wr16(`TCC_IDX_CMPA_LO, 16'h0010);
            wr16(`TCC_IDX_CMPB_LO, 16'h0010);
            wr(`TCC_IDX_CTRL_A, 8'hb0 | 8'(r));
            wr(`TCC_IDX_CTRL_B, 8'h01);
            check({31'h0, out_a_drv}, 32'h0000_0001);
            check({31'h0, out_b_drv}, 32'h0000_0001);
            // first two rises only resynchronise after the mode change
            rise(c);
            rise(c);
            rise(c);
            check(32'(c), 32'(2 * ((256 << (r - 1)) - 1)));
            // inverted b sharing the compare value clears on the same down-count match
            check({31'h0, out_b}, 32'h0000_0000);
        end
        wr16(`TCC_IDX_CMPA_LO, 16'h0020);
        rd(`TCC_IDX_CMPA_LO, 8'h20);
        wr16(`TCC_IDX_CMPA_LO, 16'h03ff);
        rd(`TCC_IDX_CMPA_HI, 8'h03);
        // one full 10-bit period so the top value latches and matches at top
        repeat (2100) @(posedge hclk);
        wr(`TCC_IDX_CTRL_A, 8'h41);
        wr(`TCC_IDX_CTRL_B, 8'h00);
        check({31'h0, out_a_drv}, 32'h0000_0000);
        check({31'h0, out_b_drv}, 32'h0000_0000);
    endtask : t_pwm
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_compare();
        t_match();
        t_capture();
        t_pwm();
        report_and_stop();
    end
endmodule : timer16_compare_capture_pwm_tb
